/* hdl/cps_fifo.sv */
// small registered fifo that sits between the image fetch and the output stage
`timescale 1ns/1ps
module cps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } cps_fifo_st_t;

    cps_fifo_st_t state_ff;   // all storage and pointers
    cps_fifo_st_t nxt_state;  // next value

    // handshakes are combinational, data comes straight from the storage flops
    assign inReady  = (state_ff.count != (AW+1)'(DEPTH));
    assign outValid = (state_ff.count != '0);
    assign outData  = state_ff.mem[state_ff.rdPtr];

    // pointer update; a flush drops everything so a new image starts clean
    always_comb begin
        nxt_state = state_ff;
        if (flush) begin
            nxt_state.wrPtr = '0;
            nxt_state.rdPtr = '0;
            nxt_state.count = '0;
        end else begin
            if (inValid && inReady) begin
                nxt_state.mem[state_ff.wrPtr] = inData;
                nxt_state.wrPtr = state_ff.wrPtr + 1'b1;
            end
            if (outValid && outReady) begin
                nxt_state.rdPtr = state_ff.rdPtr + 1'b1;
            end
            nxt_state.count = state_ff.count + (AW+1)'(inValid && inReady)
                              - (AW+1)'(outValid && outReady);
        end
    end

    // state register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

/* hdl/cps_params.svh */
// timing counts and reset values shared by the configuration data streamer
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH
`define CPS_CLK_MHZ         100
`define CPS_MAX_RATE_MHZ    33
`define CPS_ACCESS_NS       20
`define CPS_ACCESS_CYC      ((`CPS_ACCESS_NS * `CPS_CLK_MHZ + 999) / 1000)
`define CPS_RATE_DIV        ((`CPS_CLK_MHZ + `CPS_MAX_RATE_MHZ - 1) / `CPS_MAX_RATE_MHZ)
`define CPS_ADDR_RESET      0
`define CPS_FIFO_DEPTH      4
`define CPS_RUN_LEN_BIT     7
`endif

/* hdl/cps_pkg.sv */
// types shared by the configuration data streamer
package cps_pkg;
    typedef enum logic [1:0] {
        CPS_MASTER_SERIAL,
        CPS_SLAVE_SERIAL,
        CPS_MASTER_BYTE,
        CPS_SLAVE_BYTE
    } cps_mode_t;

    typedef enum logic [1:0] {
        CPS_IDLE,
        CPS_FETCH,
        CPS_RUN
    } cps_fetch_t;

    typedef struct packed {
        logic       enExtSel;
        logic [1:0] revPin;
        logic [1:0] revBits;
        logic       compressEn;
        logic       cascaded;
        logic       smallDensity;
    } cps_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
        logic       oe;
    } cps_out_t;
endpackage

/* hdl/cps_streamer.sv */
// configuration data streamer: image fetch, decompress, serial and byte output
//
// Notes on behaviour
// R1: serial bit out after access delay when enabled
// R2: next word follows each config clock rise
// R3: fpga masters clock, gives exact pulse count
// R4: slave serial external clock, optional self-drive
// R5: byte mode clock from fpga, oscillator, self
// R6: byte drive only busy low, request, enables
// R7: fpga captures byte on following rise
// R8: slave byte clock may run freely
// R9: output rate up to 33 MHz
// R10: revision from pins or internal bits
// R11: decompressor expands stored image before delivery
// R12: cascade for longer images, advanced needs same
// R13: smallest density stores revision only cascaded
// R14: programmer erases before programming, then verifies
// R15: address held at start in reset, advances
// R16: outputs high impedance unless selected and gated; code gates data outputs only, configClockOe ignores selects
`timescale 1ns/1ps
`include "cps_params.svh"
module cps_streamer #(
    parameter int ADDR_W   = 16,
    parameter int REV_W    = 2,
    parameter int DEPTH    = `CPS_FIFO_DEPTH,
    parameter int ACC_CYC  = `CPS_ACCESS_CYC,
    parameter int RATE_DIV = `CPS_RATE_DIV
) (
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire cps_pkg::cps_mode_t   mode,
    input  wire cps_pkg::cps_cfg_t    cfg,
    input  wire logic                 configClock,
    input  wire logic                 configRequest,
    input  wire logic                 chipEnable,
    input  wire logic                 outputEnable,
    input  wire logic                 busy,
    input  wire logic                 selfClockEn,
    output logic [ADDR_W+REV_W-1:0]   memAddr,
    output logic                      memRead,
    input  wire logic [7:0]           memData,
    input  wire logic                 memDataValid,
    input  wire logic                 imageEnd,
    output logic                      serialDataOut,
    output logic                      serialDataOe,
    output logic [7:0]                byteDataOut,
    output logic                      byteDataOe,
    output logic                      configClockOut,
    output logic                      configClockOe,
    output logic                      cascadeNextEn,
    output logic                      revisionError
);
    typedef struct packed {
        cps_pkg::cps_fetch_t fetch;
        logic [ADDR_W-1:0]   addr;
        logic [REV_W-1:0]    rev;
        logic [7:0]          runLeft;
        logic [7:0]          runByte;
        logic                lastClk;
        logic [7:0]          shiftReg;
        logic [3:0]          bitCnt;
        logic                haveWord;
        logic [7:0]          accCnt;
        logic                ready;
        logic [7:0]          divCnt;
        logic                genClk;
        logic                done;
        cps_pkg::cps_out_t   out;
    } cps_st_t;

    cps_st_t state_ff;   // whole block state
    cps_st_t nxt_state;  // next value

    logic       byteMode;     // one of the two byte-wide modes
    logic       selected;     // chip select and output gate both active
    logic       stream;       // delivery allowed at all
    logic       clkRise;      // rising edge of the effective config clock
    logic       effClk;       // config clock as seen by the streamer
    logic       selfDrive;    // this device drives the config clock
    logic [7:0] fifoOut;      // word at the fifo head
    logic       fifoOutValid; // fifo head valid
    logic       fifoInReady;  // room for one more word
    logic [7:0] pushData;     // word offered to the fifo
    logic       pushValid;    // push strobe
    logic       popReady;     // consume one word
    logic       revValid;     // chosen revision may be used

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // compressed run marker: top bit set means a repeat count in the low bits
    function automatic logic isRun(input logic [7:0] w, input logic en);
        isRun = en && w[`CPS_RUN_LEN_BIT];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // mode decode and enables

    assign byteMode  = (mode == cps_pkg::CPS_MASTER_BYTE) || (mode == cps_pkg::CPS_SLAVE_BYTE);
    assign selected  = chipEnable && outputEnable;
    // self-driven clock only in slave modes, master fpga always owns it
    assign selfDrive = selfClockEn && ((mode == cps_pkg::CPS_SLAVE_SERIAL) ||
                                       (mode == cps_pkg::CPS_SLAVE_BYTE));  // see R4 see R5
    assign effClk    = selfDrive ? state_ff.genClk : configClock;
    assign clkRise   = effClk && !state_ff.lastClk;
    // byte delivery also waits for busy low
    assign stream    = configRequest && selected && !(byteMode && busy);  // see R6
    // smallest density refuses a nonzero revision unless cascaded
    assign revValid  = !(cfg.smallDensity && !cfg.cascaded && (state_ff.rev != '0));  // see R13

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign memAddr        = {state_ff.rev, state_ff.addr};
    assign memRead        = (state_ff.fetch == cps_pkg::CPS_FETCH);
    assign serialDataOut  = state_ff.out.data[0];
    assign byteDataOut    = state_ff.out.data;
    // drivers released whenever select or gate drop
    assign serialDataOe   = state_ff.out.oe && !byteMode && selected;  // see R16
    assign byteDataOe     = state_ff.out.oe && byteMode && selected;   // see R16
    assign configClockOut = state_ff.genClk;
    assign configClockOe  = selfDrive;
    assign cascadeNextEn  = state_ff.done;  // see R12
    assign revisionError  = !revValid;

    // fetch path: literal words pass, runs are expanded before the fifo
    assign pushValid = (state_ff.fetch == cps_pkg::CPS_RUN) ||
                       ((state_ff.fetch == cps_pkg::CPS_FETCH) && memDataValid &&
                        !imageEnd && !isRun(memData, cfg.compressEn));  // see R11
    assign pushData  = (state_ff.fetch == cps_pkg::CPS_RUN) ? state_ff.runByte : memData;
    assign popReady  = stream && state_ff.ready && fifoOutValid &&
                       (!state_ff.haveWord || (clkRise && (byteMode || state_ff.bitCnt == 4'd1)));

    cps_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) i_cps_fifo (
        .clock    (clock),
        .rstn     (rstn),
        .flush    (!configRequest),
        .inData   (pushData),
        .inValid  (pushValid),
        .inReady  (fifoInReady),
        .outData  (fifoOut),
        .outValid (fifoOutValid),
        .outReady (popReady)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        nxt_state         = state_ff;
        nxt_state.lastClk = effClk;

        // clock divider keeps a self-driven clock at or below the top rate
        if (selfDrive) begin
            if (state_ff.divCnt >= 8'(RATE_DIV - 1)) begin
                nxt_state.divCnt = '0;
                nxt_state.genClk = !state_ff.genClk;  // see R9
            end else begin
                nxt_state.divCnt = state_ff.divCnt + 8'd1;
            end
        end else begin
            nxt_state.divCnt = '0;
            nxt_state.genClk = 1'b0;
        end

        // revision latched while request is inactive: pins or internal bits
        if (!configRequest) begin
            nxt_state.rev      = cfg.enExtSel ? cfg.revPin : cfg.revBits;  // see R10
            nxt_state.addr     = ADDR_W'(`CPS_ADDR_RESET);                 // see R15
            nxt_state.fetch    = cps_pkg::CPS_IDLE;
            nxt_state.haveWord = 1'b0;
            nxt_state.bitCnt   = '0;
            nxt_state.accCnt   = '0;
            nxt_state.ready    = 1'b0;
            nxt_state.done     = 1'b0;
            nxt_state.out      = '0;
        end else begin
            // image fetch machine
            case (state_ff.fetch)
                cps_pkg::CPS_IDLE: begin
                    if (revValid && !state_ff.done && fifoInReady) begin
                        nxt_state.fetch = cps_pkg::CPS_FETCH;
                    end
                end
                cps_pkg::CPS_FETCH: begin
                    if (memDataValid) begin
                        nxt_state.addr = state_ff.addr + 1'b1;  // see R15
                        if (imageEnd) begin
                            nxt_state.done  = 1'b1;
                            nxt_state.fetch = cps_pkg::CPS_IDLE;
                        end else if (isRun(memData, cfg.compressEn)) begin
                            // run header; the next word is the repeated byte
                            nxt_state.runLeft = {1'b0, memData[6:0]};
                            nxt_state.fetch   = cps_pkg::CPS_FETCH;
                            nxt_state.runByte = 8'h00;
                        end else if (state_ff.runLeft > 8'd1) begin
                            nxt_state.runByte = memData;
                            nxt_state.fetch   = cps_pkg::CPS_RUN;
                        end else begin
                            nxt_state.fetch = cps_pkg::CPS_IDLE;
                        end
                    end
                end
                cps_pkg::CPS_RUN: begin
                    // first copy went in with the literal; stall on a full fifo
                    if (fifoInReady) begin
                        nxt_state.runLeft = state_ff.runLeft - 8'd1;
                        if (state_ff.runLeft <= 8'd2) begin
                            nxt_state.runLeft = '0;
                            nxt_state.fetch   = cps_pkg::CPS_IDLE;
                        end
                    end
                end
                default: begin
                    nxt_state.fetch = cps_pkg::CPS_IDLE;
                end
            endcase

            // access delay before the first bit may appear after enable
            if (!selected) begin
                nxt_state.accCnt = '0;
                nxt_state.ready  = 1'b0;
            end else if (!state_ff.ready) begin
                if (state_ff.accCnt >= 8'(ACC_CYC - 1)) begin
                    nxt_state.ready = 1'b1;  // see R1
                end else begin
                    nxt_state.accCnt = state_ff.accCnt + 8'd1;
                end
            end

            // first word is presented once access delay expires
            if (state_ff.ready && stream && !state_ff.haveWord && fifoOutValid &&
                !state_ff.out.valid) begin
                nxt_state.out.data = fifoOut;  // see R1
                nxt_state.out.valid = 1'b1;
                nxt_state.out.oe   = 1'b1;
                nxt_state.haveWord = 1'b1;  // popped here, so the first rise moves on
                nxt_state.bitCnt   = 4'd8;
            end

            // each rising config clock edge launches the next bit or byte
            if (clkRise && stream && state_ff.ready && state_ff.haveWord) begin
                if (!byteMode && state_ff.bitCnt > 4'd1) begin
                    nxt_state.out.data = {1'b0, state_ff.out.data[7:1]};  // see R2
                    nxt_state.bitCnt   = state_ff.bitCnt - 4'd1;
                end else if (fifoOutValid) begin
                    nxt_state.out.data = fifoOut;  // see R2 see R6
                    nxt_state.bitCnt   = 4'd8;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; address sits at image start while reset holds

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;  // see R15
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

/* testbench/cps_fpga_model.sv */
// fpga configuration port and image memory model facing the streamer
`timescale 1ns/1ps
module cps_fpga_model #(
    parameter int AW  = 18,
    parameter int IMG = 6
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          byteMode,
    input  wire logic          busy,
    input  wire logic          serialDataOut,
    input  wire logic [7:0]    byteDataOut,
    input  wire logic [AW-1:0] memAddr,
    input  wire logic          memRead,
    input  wire logic          stall,
    input  wire logic [7:0]    pulses,
    input  wire logic          go,
    output logic               configClock,
    output logic [7:0]         memData,
    output logic               memDataValid,
    output logic               imageEnd,
    output logic [7:0]         capData,
    output logic               capStrobe,
    output logic               done
);
    logic [7:0] left;   // clock pulses still owed
    logic [2:0] phase;  // place inside one eight-cycle config clock period
    wire        hit = memRead && !memDataValid && !stall;  // word handed out this edge
    assign done = (left == 8'h0);
    // image as left by erase then program; revision 1 opens with a run code
    function automatic logic [7:0] memWord(input logic [1:0] rev, input logic [15:0] a);
        if (rev == 2'h1 && a == 16'h0) return 8'h83;
        if (rev == 2'h1 && a == 16'h1) return 8'h5A;
        return {1'b0, rev, a[4:0]} ^ 8'h15;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // memory answers at random speed; idle data flips each cycle, showing the last word and its inverse in turn
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {configClock, memData, memDataValid, imageEnd, capData, capStrobe} <= '0;
            left  <= 8'h0;
            phase <= 3'h0;
        end else begin
            memDataValid <= hit;
            memData      <= hit ? memWord(memAddr[AW-1-:2], memAddr[15:0]) : ~memData;
            imageEnd     <= hit && memAddr[15:0] == 16'(IMG);
            capStrobe    <= 1'b0;
            if (go) begin
                left  <= pulses;
                phase <= 3'h0;
            end else if (left != 8'h0) begin
                // clock idles low between frames, 12.5 MHz inside; stops once the asked pulses are given
                phase       <= phase + 3'h1;
                configClock <= phase >= 3'h3 && phase != 3'h7;
                if (phase == 3'h3 && !busy) begin
                    capStrobe <= 1'b1;
                    capData   <= byteMode ? byteDataOut : {7'h0, serialDataOut};
                end
                if (phase == 3'h7) begin
                    left <= left - 8'h1;
                end
            end
        end
    end
endmodule

/* testbench/cps_streamer_properties.sv */
// assertion checker watching the configuration data streamer ports
`timescale 1ns/1ps
module cps_streamer_properties #(
    parameter int ADDR_W = 16,
    parameter int REV_W  = 2
) (
    input wire logic                     clock,
    input wire logic                     rstn,
    input wire cps_pkg::cps_mode_t       mode,
    input wire cps_pkg::cps_cfg_t        cfg,
    input wire logic                     configClock,
    input wire logic                     configRequest,
    input wire logic                     chipEnable,
    input wire logic                     outputEnable,
    input wire logic                     busy,
    input wire logic                     selfClockEn,
    input wire logic [ADDR_W+REV_W-1:0]  memAddr,
    input wire logic                     memRead,
    input wire logic                     memDataValid,
    input wire logic                     serialDataOut,
    input wire logic                     serialDataOe,
    input wire logic [7:0]               byteDataOut,
    input wire logic                     byteDataOe,
    input wire logic                     configClockOut,
    input wire logic                     configClockOe,
    input wire logic                     revisionError
);
    wire       sel = chipEnable && outputEnable;                  // both gates open
    wire [1:0] rev = cfg.enExtSel ? cfg.revPin : cfg.revBits;     // revision asked for
    wire       useClk = configClockOe ? configClockOut : configClock;  // clock the streamer follows
    logic [3:0] quiet_ff;    // cycles the config clock has stood still, saturating
    logic       lastClk_ff;  // config clock one cycle ago
    logic       fresh_ff;    // no word fetched since the request last dropped
    ////////////////////////////////////////////////////////////////////////////////
    // helper state: counting quiet cycles avoids deep $past chains on the clock pin
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            quiet_ff   <= 4'h0;
            lastClk_ff <= 1'b0;
            fresh_ff   <= 1'b1;
        end else begin
            lastClk_ff <= useClk;
            quiet_ff   <= (useClk != lastClk_ff) ? 4'h0 : quiet_ff + 4'(quiet_ff != 4'hF);
            fresh_ff   <= !configRequest || (fresh_ff && !memDataValid);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    unsel_quiet_a: assert property (!sel && !$past(sel) |-> !serialDataOe && !byteDataOe)
        else $error("data output driven while unselected");
    serial_start_a: assert property ($rose(serialDataOe) |-> configRequest && sel)
        else $error("serial output enabled without request and selects");
    byte_start_a: assert property ($rose(byteDataOe) |-> !busy && configRequest && sel)
        else $error("byte output enabled while busy or unselected");
    byte_mode_a: assert property (byteDataOe |-> mode[1])
        else $error("byte output enabled in a serial mode");
    serial_hold_a: assert property (quiet_ff >= 6 && serialDataOe && $past(serialDataOe)
        |-> $stable(serialDataOut))
        else $error("serial data moved without a clock rise");
    byte_hold_a: assert property (quiet_ff >= 6 && byteDataOe && $past(byteDataOe)
        |-> $stable(byteDataOut))
        else $error("byte data moved without a clock rise");
    busy_hold_a: assert property (busy [*5] ##0 byteDataOe |-> $stable(byteDataOut))
        else $error("byte data advanced while busy");
    rev_addr_a: assert property (memRead |-> memAddr[ADDR_W+:REV_W] == rev)
        else $error("fetch from the wrong revision");
    start_addr_a: assert property (fresh_ff && memRead |-> memAddr[ADDR_W-1:0] == '0)
        else $error("image fetch did not start at address zero");
    small_block_a: assert property (revisionError |-> !memRead)
        else $error("fetch while the revision is refused");
    rev_error_a: assert property (!configRequest && !$past(configRequest) && $stable(cfg)
        |-> revisionError == (cfg.smallDensity && !cfg.cascaded && rev != 2'h0))
        else $error("revision refusal flag wrong");
    clk_drive_a: assert property (configClockOe |-> (selfClockEn || $past(selfClockEn))
        && (mode[0] || $past(mode[0])))
        else $error("config clock driven outside slave self-clock");
    clk_rate_a: assert property (configClockOe && $past(configClockOe) && $changed(configClockOut)
        |=> ($stable(configClockOut) || !configClockOe) [*3]
        ##1 ($changed(configClockOut) || !configClockOe))
        else $error("driven config clock half period not four cycles");
    cover property ($rose(serialDataOe));
    cover property ($rose(byteDataOe) && mode == cps_pkg::CPS_SLAVE_BYTE);
    cover property (revisionError);
    cover property ($rose(configClockOe));
endmodule
bind cps_streamer cps_streamer_properties #(.ADDR_W(ADDR_W), .REV_W(REV_W))
    i_cps_streamer_properties (.*);

/* testbench/test_cps_streamer.sv */
// self-checking bench for the configuration data streamer
`timescale 1ns/1ps
module test_cps_streamer;
    logic               clock, rstn, configRequest, chipEnable, outputEnable, busy;
    logic               selfClockEn, go, configClock, memRead, memDataValid, imageEnd;
    logic               serialDataOut, serialDataOe, byteDataOe, configClockOut, configClockOe;
    logic               cascadeNextEn, revisionError, capStrobe, done;
    logic               stall = 1'b0;
    cps_pkg::cps_mode_t mode;
    cps_pkg::cps_cfg_t  cfg;
    logic [7:0]         pulses, memData, byteDataOut, capData;
    logic [17:0]        memAddr;
    logic [31:0]        seed = 32'hA5A06CFC;
    logic [7:0]         expQ[$];  // expected captures, oldest first
    int                 n_fail = 0;
    int                 checks = 0;
    cps_streamer   i_cps_streamer (.*);
    cps_fpga_model i_cps_fpga_model (.byteMode(mode[1]), .*);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // restart: mode and settings change only with request and selects low
    task automatic open(input cps_pkg::cps_mode_t m, input logic [7:0] c);
        @(negedge clock);
        {configRequest, chipEnable, outputEnable} = 3'h0;
        repeat (3) @(negedge clock);
        mode = m;
        cfg  = cps_pkg::cps_cfg_t'(c);
        repeat (3) @(negedge clock);
        {configRequest, chipEnable, outputEnable} = 3'h7;
        repeat (30) @(negedge clock);
    endtask
    // ask the fpga model for n config clock pulses and wait until they are given
    task automatic run(input logic [7:0] n);
        int i;
        pulses = n;
        go     = 1'b1;
        @(negedge clock);
        go = 1'b0;
        for (i = 0; i < 2500 && done !== 1'b1; i++) @(negedge clock);
        chk("run done", 8'(done), 8'h1);
        repeat (8) @(negedge clock);
    endtask
    task automatic note(input logic [7:0] w, input bit serial);
        int b;
        if (!serial) expQ.push_back(w);
        else for (b = 0; b < 8; b++) expQ.push_back({7'h0, w[b]});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // random memory stalls reach the fetch side
    always @(negedge clock) begin
        seed  = xs(seed);
        stall = seed[0];
    end
    // monitor: each capture by the fpga model is matched against the oldest note
    always @(negedge clock) begin
        if (capStrobe === 1'b1) begin
            if (expQ.size() == 0) chk("extra capture", capData, 8'hEE);
            else chk("stream", capData, expQ.pop_front());
        end
    end
    initial begin
        #300us;
        n_fail++;
        give_verdict();
    end
    initial begin
        {configRequest, chipEnable, outputEnable, busy, selfClockEn, go} = '0;
        pulses = 8'h0;
        mode   = cps_pkg::CPS_MASTER_SERIAL;
        cfg    = '0;
        rstn   = 1'b0;
        repeat (3) @(negedge clock);
        rstn = 1'b1;
        // serial, internal revision 0, two words lsb first, then deselect
        open(cps_pkg::CPS_MASTER_SERIAL, 8'h00);
        for (int a = 0; a < 2; a++) note(i_cps_fpga_model.memWord(2'h0, 16'(a)), 1);
        run(8'd8);
        chk("cascade early", 8'(cascadeNextEn), 8'h0);
        run(8'd8);
        chipEnable = 1'b0;
        repeat (3) @(negedge clock);
        chk("serial oe off", 8'(serialDataOe), 8'h0);
        // byte mode, revision 2 from pins, busy stalls in mid-image
        open(cps_pkg::CPS_MASTER_BYTE, 8'hC0);
        for (int a = 0; a < 6; a++) note(i_cps_fpga_model.memWord(2'h2, 16'(a)), 0);
        run(8'd2);
        busy = 1'b1;
        run(8'd3);
        busy = 1'b0;
        run(8'd4);
        chk("cascade after end", 8'(cascadeNextEn), 8'h1);
        // slave byte, compressed revision 1: one run of three, then plain words
        open(cps_pkg::CPS_SLAVE_BYTE, 8'h0C);
        repeat (3) note(8'h5A, 0);
        for (int a = 2; a < 6; a++) note(i_cps_fpga_model.memWord(2'h1, 16'(a)), 0);
        run(8'd7);
        // self clock drive only in slave modes
        selfClockEn = 1'b1;
        open(cps_pkg::CPS_SLAVE_SERIAL, 8'h00);
        chk("clock oe slave", 8'(configClockOe), 8'h1);
        open(cps_pkg::CPS_MASTER_SERIAL, 8'h00);
        chk("clock oe master", 8'(configClockOe), 8'h0);
        selfClockEn = 1'b0;
        // small density: revision refused alone, allowed when cascaded
        open(cps_pkg::CPS_MASTER_SERIAL, 8'h09);
        chk("rev refused", 8'(revisionError), 8'h1);
        open(cps_pkg::CPS_MASTER_SERIAL, 8'h0B);
        chk("rev cascaded", 8'(revisionError), 8'h0);
        chk("left over notes", 8'(expQ.size()), 8'h0);
        give_verdict();
    end
endmodule
